// file: verilog/cmr_pkg.sv
// Purpose: Shared constants and types of the charger configuration register bank
// Assumes: Byte-wide registers on a serial two-wire port
// Notes:   Register index order is fixed by REG_ADDRS below

package cmr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int         NUM_REGS    = 6;
    localparam logic [7:0] MASK_C_ADDR = 8'h0A;
    localparam logic [7:0] VBAT_ADDR   = 8'h12;
    localparam logic [7:0] ICHG_ADDR   = 8'h13;
    localparam logic [7:0] PCHG_ADDR   = 8'h14;
    localparam logic [7:0] TERM_ADDR   = 8'h15;
    localparam logic [7:0] BATUV_ADDR  = 8'h16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_C_RST  = 8'h00;
    localparam logic [7:0] VBAT_RST    = 8'h3C;
    localparam logic [7:0] ICHG_RST    = 8'h08;
    localparam logic [7:0] PCHG_RST    = 8'h02;
    localparam logic [7:0] TERM_RST    = 8'h14;
    localparam logic [7:0] BATUV_RST   = 8'h00;

    // Register indices into the storage array
    localparam int REG_MASK_C = 0;
    localparam int REG_VBAT   = 1;
    localparam int REG_ICHG   = 2;
    localparam int REG_PCHG   = 3;
    localparam int REG_TERM   = 4;
    localparam int REG_BATUV  = 5;

    localparam logic [NUM_REGS-1:0][7:0] REG_ADDRS =
        {BATUV_ADDR, TERM_ADDR, PCHG_ADDR, ICHG_ADDR, VBAT_ADDR, MASK_C_ADDR};
    localparam logic [NUM_REGS-1:0][7:0] REG_RSTS =
        {BATUV_RST, TERM_RST, PCHG_RST, ICHG_RST, VBAT_RST, MASK_C_RST};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WD_MASK_BIT     = 6;
    localparam int SAFETY_MASK_BIT = 5;
    localparam int LDO_MASK_BIT    = 4;
    localparam int WAKE1_MASK_BIT  = 2;
    localparam int WAKE2_MASK_BIT  = 1;
    localparam int RSTW_MASK_BIT   = 0;
    localparam int VBAT_MSB        = 6;
    localparam int STEP_SEL_BIT    = 7;
    localparam int PCHG_MSB        = 4;
    localparam int TERM_MSB        = 5;
    localparam int TERM_LSB        = 1;
    localparam int TERM_DIS_BIT    = 0;
    localparam int THRESH_SEL_BIT  = 5;
    localparam int OCP_MSB         = 4;
    localparam int OCP_LSB         = 3;
    localparam int UVLO_MSB        = 2;

    // ------------------------------------------------------------
    // Regulation voltage limits
    // ------------------------------------------------------------
    localparam int         VBAT_BASE_MV  = 3600;
    localparam int         VBAT_STEP_MV  = 10;
    localparam int         VBAT_LIMIT_MV = 4600;
    localparam logic [6:0] VBAT_CODE_MAX = 7'((VBAT_LIMIT_MV - VBAT_BASE_MV) / VBAT_STEP_MV);

    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } cmr_state_t;

endpackage : cmr_pkg

// file: verilog/cmr_reg_if.sv
// Purpose: Carrier between the serial engine and the register store
// Assumes: One write strobe per committed byte
// Notes:   Read data is registered in the store

interface cmr_reg_if;
    import cmr_pkg::*;
    logic [7:0] addr;
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] val [NUM_REGS];

    modport bus  (output addr, wr_en, wr_data, input rd_data, val);
    modport regs (input addr, wr_en, wr_data, output rd_data, val);
endinterface : cmr_reg_if

// file: verilog/cmr_sync.sv
// Purpose: Two-stage synchroniser for the serial pins
// Assumes: Idle level of the pins is high
// Notes:   Only the second stage is visible outside

module cmr_sync import cmr_pkg::*; #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // Pins in, synchronised out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '1;
            sync_r <= '1;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule : cmr_sync

// file: verilog/cmr_regfile.sv
// Purpose: Storage of the six configuration registers
// Assumes: Writes are whole bytes, reads are free of side effects
// Notes:   Unmapped offsets read zero and ignore writes

module cmr_regfile import cmr_pkg::*; (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // Register access
    cmr_reg_if.regs   rif
);

    logic [NUM_REGS-1:0] hit;
    logic [7:0]          rd_mux;
    logic [7:0]          rd_data_r;

    // ------------------------------------------------------------
    // Per-register storage
    // ------------------------------------------------------------
    // Reserved bits are stored as written; software sees them back
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
        assign hit[i] = (rif.addr == REG_ADDRS[i]);
        always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
                rif.val[i] <= REG_RSTS[i];
            end else if (rif.wr_en && hit[i]) begin
                rif.val[i] <= rif.wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        for (int j = 0; j < NUM_REGS; j++) begin
            if (hit[j]) begin
                rd_mux = rif.val[j];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_mux;
        end
    end

    assign rif.rd_data = rd_data_r;

endmodule : cmr_regfile

// file: verilog/cmr_config_regs.sv
// Purpose: Charger configuration and interrupt mask registers behind a two-wire slave
// Assumes: SCL is far slower than ref_clk; host never stretches or arbitrates
// Notes:   Pointer auto-increments after every data byte
//
// Contract
// - Mask bit 6 blocks watchdog fault interrupt
// - Mask bit 5 blocks safety timer interrupt
// - Mask bit 4 blocks regulator overcurrent interrupt
// - Mask bit 2 blocks first wake timeout
// - Mask bit 1 blocks second wake timeout
// - Mask bit 0 blocks reset warning interrupt
// - Mask register at 0x0A, resets zero
// - Voltage code bits 6:0, 10 mV steps
// - Effective voltage saturates at 4.6 V
// - Voltage register 0x12 resets to 0x3C
// - Fast charge code scaled by step select
// - Fast charge register 0x13 resets 0x08
// - Pre-charge bit 7 selects current step
// - Pre-charge code bits 4:0 scaled likewise
// - Pre-charge register 0x14 resets 0x02
// - Termination code bits 5:1, percent steps
// - Termination register 0x15 resets 0x14
// - Termination bit 0 disables termination
// - Undervoltage register 0x16 fields, resets zero
// - Threshold select bit picks 3.0/2.8 V

module cmr_config_regs import cmr_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h2A    // Arbitrary slave address
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Two-wire host port
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Interrupt sources and request
    input  wire logic [5:0] irq_src,
    output logic            irq_o,
    // Charger settings
    output logic [6:0]      battery_target_voltage,
    output logic [7:0]      fast_charge_code,
    output logic            charge_step_select,
    output logic [4:0]      precharge_code,
    output logic [4:0]      termination_percent_code,
    output logic            termination_disable,
    output logic            precharge_threshold_select,
    output logic [1:0]      battery_overcurrent_limit,
    output logic [2:0]      battery_undervoltage_level
);

    // ------------------------------------------------------------
    // Pin synchronisation and bus events
    // ------------------------------------------------------------
    logic [1:0] pin_s;
    logic       scl_d_r;
    logic       sda_d_r;

    cmr_sync #(.W(2)) u_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .din     ({scl_i, sda_i}),
        .dout    (pin_s)
    );

    wire scl_s     = pin_s[1];
    wire sda_s     = pin_s[0];
    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire start_c   = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c    = scl_s & scl_d_r & ~sda_d_r & sda_s;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // Register store
    // ------------------------------------------------------------
    cmr_reg_if rif ();

    cmr_regfile u_regfile (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .rif     (rif)
    );

    // ------------------------------------------------------------
    // Serial engine state
    // ------------------------------------------------------------
    cmr_state_t state_r, state_nxt;
    logic [3:0] cnt_r,   cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] ptr_r,   ptr_nxt;
    logic [7:0] tx_r,    tx_nxt;
    logic       oe_r,    oe_nxt;
    logic       ack_r,   ack_nxt;
    logic       wr_r,    wr_nxt;
    logic       sda_o_r;

    wire byte_done = scl_fall && (cnt_r == BYTE_BITS);
    wire addr_hit  = (shift_r[7:1] == DEV_ADDR);
    wire rd_bit    = shift_r[0];
    wire [7:0] ptr_inc = ptr_r + 8'h01;

    // Commit lands on the SCL fall that ends the eighth bit, before the ack slot, so writes act at once
    assign rif.addr    = ptr_r;
    assign rif.wr_en   = wr_r;
    assign rif.wr_data = shift_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        ptr_nxt   = ptr_r;
        tx_nxt    = tx_r;
        oe_nxt    = oe_r;
        ack_nxt   = ack_r;
        wr_nxt    = 1'b0;
        if (stop_c) begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
        end else if (start_c) begin
            state_nxt = ST_ADDR;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt   = cnt_r + 4'h1;
                    end else if (byte_done) begin
                        cnt_nxt = 4'h0;
                        oe_nxt  = 1'b1;
                        if (state_r == ST_ADDR) begin
                            state_nxt = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                            oe_nxt    = addr_hit;
                        end else if (state_r == ST_REG) begin
                            ptr_nxt   = shift_r;
                            state_nxt = ST_REG_ACK;
                        end else begin
                            wr_nxt    = 1'b1;
                            state_nxt = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall && rd_bit) begin
                        oe_nxt    = ~rif.rd_data[7];
                        tx_nxt    = {rif.rd_data[6:0], 1'b0};
                        state_nxt = ST_RDATA;
                    end else if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = ST_REG;
                    end
                end
                ST_REG_ACK: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        ptr_nxt   = ptr_inc;
                        state_nxt = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (byte_done) begin
                        oe_nxt    = 1'b0;
                        cnt_nxt   = 4'h0;
                        ptr_nxt   = ptr_inc;
                        state_nxt = ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        oe_nxt = ~tx_r[7];
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        ack_nxt = ~sda_s;
                    end else if (scl_fall && ack_r) begin
                        // Pointer moved long before this edge, so read data is settled
                        oe_nxt    = ~rif.rd_data[7];
                        tx_nxt    = {rif.rd_data[6:0], 1'b0};
                        state_nxt = ST_RDATA;
                    end else if (scl_fall) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            ptr_r   <= 8'h00;
            tx_r    <= 8'h00;
            oe_r    <= 1'b0;
            ack_r   <= 1'b0;
            wr_r    <= 1'b0;
            sda_o_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r   <= ptr_nxt;
            tx_r    <= tx_nxt;
            oe_r    <= oe_nxt;
            ack_r   <= ack_nxt;
            wr_r    <= wr_nxt;
            sda_o_r <= 1'b0;
        end
    end

    // Open drain: the line is only ever pulled low
    assign sda_o  = sda_o_r;
    assign sda_oe = oe_r;

    // ------------------------------------------------------------
    // Interrupt gating
    // ------------------------------------------------------------
    wire [7:0] mask_reg = rif.val[REG_MASK_C];
    wire [5:0] mask_vec;
    logic      irq_r;

    assign mask_vec[5] = mask_reg[WD_MASK_BIT];
    assign mask_vec[4] = mask_reg[SAFETY_MASK_BIT];
    assign mask_vec[3] = mask_reg[LDO_MASK_BIT];
    assign mask_vec[2] = mask_reg[WAKE1_MASK_BIT];
    assign mask_vec[1] = mask_reg[WAKE2_MASK_BIT];
    assign mask_vec[0] = mask_reg[RSTW_MASK_BIT];

    wire irq_any = |(irq_src & ~mask_vec);

    // ------------------------------------------------------------
    // Effective charger settings
    // ------------------------------------------------------------
    wire [6:0] vbat_code = rif.val[REG_VBAT][VBAT_MSB:0];
    // Stored code reads back unchanged; only the applied value is clamped
    wire [6:0] vbat_eff  = (vbat_code > VBAT_CODE_MAX) ? VBAT_CODE_MAX : vbat_code;
    wire [7:0] pchg_reg  = rif.val[REG_PCHG];
    wire [7:0] term_reg  = rif.val[REG_TERM];
    wire [7:0] batuv_reg = rif.val[REG_BATUV];

    logic [6:0] vbat_r;
    logic [7:0] ichg_r;
    logic       step_r;
    logic [4:0] pchg_r;
    logic [4:0] term_r;
    logic       term_dis_r;
    logic       thresh_r;
    logic [1:0] ocp_r;
    logic [2:0] uvlo_r;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_r      <= 1'b0;
            vbat_r     <= VBAT_RST[VBAT_MSB:0];
            ichg_r     <= ICHG_RST;
            step_r     <= PCHG_RST[STEP_SEL_BIT];
            pchg_r     <= PCHG_RST[PCHG_MSB:0];
            term_r     <= TERM_RST[TERM_MSB:TERM_LSB];
            term_dis_r <= TERM_RST[TERM_DIS_BIT];
            thresh_r   <= BATUV_RST[THRESH_SEL_BIT];
            ocp_r      <= BATUV_RST[OCP_MSB:OCP_LSB];
            uvlo_r     <= BATUV_RST[UVLO_MSB:0];
        end else begin
            irq_r      <= irq_any;
            vbat_r     <= vbat_eff;
            ichg_r     <= rif.val[REG_ICHG];
            step_r     <= pchg_reg[STEP_SEL_BIT];
            pchg_r     <= pchg_reg[PCHG_MSB:0];
            term_r     <= term_reg[TERM_MSB:TERM_LSB];
            term_dis_r <= term_reg[TERM_DIS_BIT];
            thresh_r   <= batuv_reg[THRESH_SEL_BIT];
            ocp_r      <= batuv_reg[OCP_MSB:OCP_LSB];
            uvlo_r     <= batuv_reg[UVLO_MSB:0];
        end
    end

    assign irq_o                      = irq_r;
    assign battery_target_voltage     = vbat_r;
    assign fast_charge_code           = ichg_r;
    assign charge_step_select         = step_r;
    assign precharge_code             = pchg_r;
    assign termination_percent_code   = term_r;
    assign termination_disable        = term_dis_r;
    assign precharge_threshold_select = thresh_r;
    assign battery_overcurrent_limit  = ocp_r;
    assign battery_undervoltage_level = uvlo_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    wd_mask_a: assert property (
        (irq_src == 6'h20) && mask_reg[6] |=> !irq_o)
        else $error("watchdog interrupt passed while masked");

    safety_pass_a: assert property (
        (irq_src == 6'h10) && !mask_reg[5] |=> irq_o)
        else $error("unmasked safety timer interrupt lost");

    ldo_mask_a: assert property (
        (irq_src == 6'h08) && mask_reg[4] |=> !irq_o)
        else $error("regulator overcurrent passed while masked");

    wake1_pass_a: assert property (
        (irq_src == 6'h04) && !mask_reg[2] |=> irq_o)
        else $error("unmasked first wake timeout lost");

    wake2_mask_a: assert property (
        (irq_src == 6'h02) && mask_reg[1] |=> !irq_o)
        else $error("second wake timeout passed while masked");

    rstw_gate_a: assert property (
        (irq_src == 6'h01) |=> (irq_o == !$past(mask_reg[0])))
        else $error("reset warning gating wrong");

    reset_vals_a: assert property (
        $rose(reset_n) |-> (rif.val[REG_VBAT] == 8'h3C) && (rif.val[REG_MASK_C] == 8'h00)
            && (rif.val[REG_ICHG] == 8'h08) && (rif.val[REG_PCHG] == 8'h02)
            && (rif.val[REG_TERM] == 8'h14) && (rif.val[REG_BATUV] == 8'h00))
        else $error("register reset values wrong");

    vbat_clamp_a: assert property (
        (vbat_code > 7'h64) [*2] |-> battery_target_voltage == 7'h64)
        else $error("regulation code not saturated");

    vbat_pass_a: assert property (
        (vbat_code <= 7'h64) |=> battery_target_voltage == $past(vbat_code))
        else $error("regulation code not applied");

    write_back_a: assert property (
        rif.wr_en && (rif.addr == 8'h15) |=> (rif.val[REG_TERM] == $past(rif.wr_data))
            ##1 (termination_disable == $past(rif.val[REG_TERM][0], 1)))
        else $error("termination register write not applied");

    step_sel_a: assert property (
        $changed(pchg_reg[7]) |=> charge_step_select == pchg_reg[7])
        else $error("step select not following register");

    oe_state_a: assert property (
        sda_oe |-> state_r inside {ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK, ST_RDATA, ST_ADDR})
        else $error("data line driven outside an ack or read slot");

    write_cov: cover property (rif.wr_en && (rif.addr == VBAT_ADDR));
    read_cov:  cover property ((state_r == ST_RDATA_ACK) && scl_fall && ack_r);
    irq_cov:   cover property ($rose(irq_o));
    clamp_cov: cover property (vbat_code > VBAT_CODE_MAX);

endmodule : cmr_config_regs

// file: verification/cmr_host_model.sv
// Purpose: Two-wire host model for the register port
// Assumes: Line pulled up; the device only pulls it low
// Notes:   SDA moves 3 cycles after SCL falls to avoid false START/STOP
module cmr_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    // Clock and device pull
    input  wire logic ref_clk,
    input  wire logic sda_oe,
    // Host lines
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hp(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hp
    task automatic start();
        hp(3);
        sda = 1'b1;
        hp(10);
        scl = 1'b1;
        hp(10);
        sda = 1'b0;
        hp(10);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        hp(3);
        sda = 1'b0;
        hp(10);
        scl = 1'b1;
        hp(10);
        sda = 1'b1;
        hp(10);
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        hp(3);
        sda = b;
        hp(10);
        scl = 1'b1;
        hp(10);
        r = sda & ~sda_oe;
        scl = 1'b0;
    endtask : bitx
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q = {q[6:0], r};
        end
        bitx(a, r);
    endtask : xfer
    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ra, 1'b1, q);
        xfer(d, 1'b1, q);
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] ra, output logic [7:0] q);
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ra, 1'b1, q);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q);
        xfer(8'hFF, 1'b1, q);
        stop();
    endtask : rd
    task automatic wr2(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1);
        logic [7:0] q;
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q);
        xfer(ra, 1'b1, q);
        xfer(d0, 1'b1, q);
        xfer(d1, 1'b1, q);
        stop();
    endtask : wr2
    // Host acknowledges the first data byte so the device sends a second one
    task automatic rd2(input logic [7:0] ra, output logic [7:0] q0, output logic [7:0] q1);
        start();
        xfer({DEV_ADDR, 1'b0}, 1'b1, q0);
        xfer(ra, 1'b1, q0);
        start();
        xfer({DEV_ADDR, 1'b1}, 1'b1, q0);
        xfer(8'hFF, 1'b0, q0);
        xfer(8'hFF, 1'b1, q1);
        stop();
    endtask : rd2
endmodule : cmr_host_model

// file: verification/cmr_config_regs_test.sv
// Purpose: Self-checking bench of the configuration register bank
// Assumes: Host model on the two-wire port, sources driven directly
// Notes:   Termination code is never written as zero
module cmr_config_regs_test import cmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, scl, sda_h, sda_o, sda_oe, irq_o, step, tdis, thr;
    logic [5:0] irq_src;
    logic [6:0] vbat;
    logic [7:0] ichg, q;
    logic [4:0] pchg, term;
    logic [1:0] ocp;
    logic [2:0] uvlo;
    int fails = 0;
    int checks_done = 0;
    cmr_config_regs i_cmr_config_regs (.ref_clk, .reset_n, .scl_i(scl), .sda_i(sda_h & ~sda_oe), .sda_o, .sda_oe,
        .irq_src, .irq_o, .battery_target_voltage(vbat), .fast_charge_code(ichg), .charge_step_select(step),
        .precharge_code(pchg), .termination_percent_code(term), .termination_disable(tdis),
        .precharge_threshold_select(thr), .battery_overcurrent_limit(ocp), .battery_undervoltage_level(uvlo));
    cmr_host_model i_cmr_host_model (.ref_clk, .sda_oe, .scl, .sda(sda_h));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        i_cmr_host_model.rd(a, q);
        chk(q, exp);
    endtask : rc
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NUM_REGS; i++) rc(REG_ADDRS[i], REG_RSTS[i]);
        chk({1'b0, vbat}, 8'h3C);
        chk(ichg, 8'h08);
        chk({3'h0, pchg}, 8'h02);
        chk({3'h0, term}, 8'h0A);
        chk({step, tdis, thr, ocp, uvlo}, 8'h00);
        chk({7'h0, sda_o}, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_mask();
        int mb[6] = '{RSTW_MASK_BIT, WAKE2_MASK_BIT, WAKE1_MASK_BIT, LDO_MASK_BIT, SAFETY_MASK_BIT, WD_MASK_BIT};
        for (int i = 0; i < 6; i++) begin
            irq_src = 6'h01 << i;
            i_cmr_host_model.wr(MASK_C_ADDR, 8'hFF ^ (8'h01 << mb[i]));
            chk({7'h0, irq_o}, 8'h01);
            i_cmr_host_model.wr(MASK_C_ADDR, 8'h88 | (8'h01 << mb[i]));
            chk({7'h0, irq_o}, 8'h00);
            rc(MASK_C_ADDR, 8'h88 | (8'h01 << mb[i]));
        end
        irq_src = 6'h00;
        $display("mask test done");
    endtask : t_mask
    task automatic t_vbat();
        logic [7:0] vv[5] = '{8'h7F, 8'h65, 8'h64, 8'h63, 8'hBC};
        for (int i = 0; i < 5; i++) begin
            i_cmr_host_model.wr(VBAT_ADDR, vv[i]);
            chk({1'b0, vbat}, (vv[i][6:0] > VBAT_CODE_MAX) ? {1'b0, VBAT_CODE_MAX} : {1'b0, vv[i][6:0]});
            rc(VBAT_ADDR, vv[i]);
        end
        $display("voltage test done");
    endtask : t_vbat
    task automatic t_cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
        logic [7:0] v[4] = '{a, b, c, d};
        for (int i = 0; i < 4; i++) i_cmr_host_model.wr(ICHG_ADDR + 8'(i), v[i]);
        chk(ichg, a);
        chk({step, 2'h0, pchg}, b & 8'h9F);
        chk({2'h0, term, tdis}, c & 8'h3F);
        chk({2'h0, thr, ocp, uvlo}, d & 8'h3F);
        for (int i = 0; i < 4; i++) rc(ICHG_ADDR + 8'(i), v[i]);
        $display("settings test done");
    endtask : t_cfg
    task automatic t_burst();
        logic [7:0] q1;
        i_cmr_host_model.wr2(TERM_ADDR, 8'h06, 8'h2B);
        i_cmr_host_model.rd2(TERM_ADDR, q, q1);
        chk(q, 8'h06);
        chk(q1, 8'h2B);
        chk({2'h0, term, tdis}, 8'h06);
        chk({2'h0, thr, ocp, uvlo}, 8'h2B);
        $display("burst test done");
    endtask : t_burst
    task automatic t_unmapped();
        i_cmr_host_model.wr(8'h0B, 8'h5A);
        rc(8'h0B, 8'h00);
        rc(MASK_C_ADDR, 8'h88 | (8'h01 << WD_MASK_BIT));
        $display("unmapped test done");
    endtask : t_unmapped
    initial begin
        #800us;
        fails++;
        print_verdict();
    end
    initial begin
        reset_n = 1'b0;
        irq_src = 6'h00;
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge ref_clk);
        t_reset();
        t_mask();
        t_vbat();
        t_cfg(8'hA5, 8'h9F, 8'h3F, 8'h3F);
        t_cfg(8'h5A, 8'h60, 8'hC2, 8'hD5);
        t_burst();
        t_unmapped();
        print_verdict();
    end
endmodule : cmr_config_regs_test
